// [verilog/float_unit.sv]
// float unit: four 64-bit float registers, status, stack block, skips, AHB-Lite slave
// assumes one AHB-Lite master, word transfers only, and a sequencer interrupt on clk
`timescale 1ns/1ps
`include "fpu_map.svh"

module float_unit
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic intr_req,
  output logic busy,
  output logic done,
  output logic skip_taken
);
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [11:0] dp_addr_reg;
  logic rd_wait_reg;
  logic rd_stall;
  logic addr_phase;
  logic wr_en;
  logic [31:0] rd_mux;
  fpu_pkg::seq_state_e state_reg;
  fpu_pkg::op_e op_reg;
  logic [1:0] src_reg;
  logic [1:0] dst_reg;
  logic [4:0] cnt_reg;
  logic [63:0] freg_reg [0:3];
  logic [31:0] fsr_reg;
  logic [15:0] ac0_reg;
  logic [15:0] pc_reg;
  logic [15:0] sp_reg;
  logic [15:0] opw_reg [0:3];
  logic [15:0] stack_mem [0:31];
  logic [15:0] shadow_reg [0:17];
  logic sw_idle;
  logic push_fin;
  logic pop_fin;
  logic exec_fin;
  logic [63:0] fa;
  logic [63:0] fb;
  logic [47:0] product;
  logic [59:0] small_al;
  logic [59:0] scale_sh;
  logic [60:0] sum;
  logic sum_sign;
  logic a_big;
  logic [6:0] exp_diff;
  logic [9:0] scale_diff;
  logic [6:0] scale_amt;
  logic n_sign;
  logic [9:0] n_exp;
  logic [59:0] n_mant;
  logic [63:0] n_result;
  logic n_over;
  logic n_under;
  logic [63:0] res_val;
  logic res_wr;
  logic set_ovf;
  logic set_unf;
  logic set_mof;
  logic skip;
  logic [4:0] push_idx;
  logic [4:0] pop_idx;
  logic [15:0] push_word;

  // bus slave: address phase latch, one wait state on every read
  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_stall = dp_valid_reg && !dp_write_reg && !rd_wait_reg;
  assign hreadyout = !rd_stall;
  assign hresp = 1'b0;
  assign wr_en = dp_valid_reg && dp_write_reg;
  assign sw_idle = state_reg == fpu_pkg::st_idle;
  assign busy = !sw_idle;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 12'h000;
      rd_wait_reg <= 1'b0;
      hrdata <= 32'h0;
    end
    else
    begin
      if (hready)
      begin
        dp_valid_reg <= addr_phase;
        dp_write_reg <= hwrite;
        dp_addr_reg <= {haddr[11:2], 2'b00};
      end
      rd_wait_reg <= rd_stall;
      if (rd_stall)
        hrdata <= rd_mux;
    end
  end

  // read decode; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h0;
    if (dp_addr_reg == `REG_CMD)
      rd_mux = {18'h0, dst_reg, 2'b00, src_reg, 3'h0, op_reg};
    else if (dp_addr_reg == `REG_STATUS)
      rd_mux = {30'h0, skip_taken, busy};
    else if (dp_addr_reg == `REG_FSR)
      rd_mux = fsr_reg;
    else if (dp_addr_reg == `REG_AC0)
      rd_mux = {16'h0, ac0_reg};
    else if (dp_addr_reg == `REG_PC)
      rd_mux = {16'h0, pc_reg};
    else if (dp_addr_reg == `REG_SP)
      rd_mux = {16'h0, sp_reg};
    else if (dp_addr_reg >= `REG_OPW0 && dp_addr_reg < `REG_OPW0 + 12'h010)
      rd_mux = {16'h0, opw_reg[dp_addr_reg[3:2] - 2'h2]};
    else if (dp_addr_reg >= `REG_FREG0 && dp_addr_reg < `REG_FREG_END)
      rd_mux = dp_addr_reg[2] ? freg_reg[dp_addr_reg[4:3]][31:0]
                              : freg_reg[dp_addr_reg[4:3]][63:32];
    else if (dp_addr_reg >= `REG_STACK0 && dp_addr_reg < `REG_STACK_END)
      rd_mux = {16'h0, stack_mem[dp_addr_reg[6:2]]};
  end

  // sequencer; an interrupt abandons push or pop with sp and pc unchanged; pop commits nothing, push has already written stack words
  assign push_fin = state_reg == fpu_pkg::st_push && cnt_reg == `BLOCK_LAST && !intr_req;
  assign pop_fin = state_reg == fpu_pkg::st_pop && cnt_reg == `BLOCK_WORDS && !intr_req;
  assign exec_fin = state_reg == fpu_pkg::st_exec;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= fpu_pkg::st_idle;
      op_reg <= fpu_pkg::float_no_skip;
      src_reg <= 2'h0;
      dst_reg <= 2'h0;
      cnt_reg <= 5'h00;
      done <= 1'b0;
      skip_taken <= 1'b0;
    end
    else
    begin
      done <= exec_fin || push_fin || pop_fin;
      unique case (state_reg)
        fpu_pkg::st_idle:
        begin
          cnt_reg <= 5'h00;
          if (wr_en && dp_addr_reg == `REG_CMD)
          begin
            op_reg <= fpu_pkg::op_e'(hwdata[`CMD_OP_MSB:0]);
            src_reg <= hwdata[`CMD_SRC_LSB +: 2];
            dst_reg <= hwdata[`CMD_DST_LSB +: 2];
            if (hwdata[`CMD_OP_MSB:0] == 5'(fpu_pkg::push_float_state))
              state_reg <= fpu_pkg::st_push;
            else if (hwdata[`CMD_OP_MSB:0] == 5'(fpu_pkg::pop_float_state))
              state_reg <= fpu_pkg::st_pop;
            else
              state_reg <= fpu_pkg::st_exec;
          end
        end
        fpu_pkg::st_exec:
        begin
          skip_taken <= skip;
          state_reg <= fpu_pkg::st_idle;
        end
        fpu_pkg::st_push, fpu_pkg::st_pop:
        begin
          cnt_reg <= cnt_reg + 5'h01;
          if (intr_req || push_fin || pop_fin)
            state_reg <= fpu_pkg::st_idle;
          if (push_fin || pop_fin)
            skip_taken <= 1'b0;
        end
      endcase
    end
  end

  // operands: source is a register or the memory operand words
  assign fa = freg_reg[dst_reg];
  always_comb
  begin
    fb = freg_reg[src_reg];
    if (op_reg == fpu_pkg::subtract_double_memory)
      fb = {opw_reg[0], opw_reg[1], opw_reg[2], opw_reg[3]};
    else if (op_reg == fpu_pkg::subtract_single_memory)
      fb = {opw_reg[0], opw_reg[1], 32'h0};
  end

  // multiply on the high halves only, low halves taken as zero
  assign product = fa[55:32] * fb[55:32];

  // subtract: source sign inverted, smaller operand aligned to the larger
  assign a_big = fa[62:56] >= fb[62:56];
  assign exp_diff = a_big ? fa[62:56] - fb[62:56] : fb[62:56] - fa[62:56];

  hex_shifter align_shift
  (
    .in_val(a_big ? {fb[55:0], 4'h0} : {fa[55:0], 4'h0}),
    .amount(exp_diff),
    .left(1'b0),
    .out_val(small_al)
  );

  // magnitude add or subtract of aligned mantissas
  always_comb
  begin
    logic [59:0] big_m;
    logic big_s;
    logic small_s;
    big_m = a_big ? {fa[55:0], 4'h0} : {fb[55:0], 4'h0};
    big_s = a_big ? fa[63] : !fb[63];
    small_s = a_big ? !fb[63] : fa[63];
    sum_sign = big_s;
    if (big_s == small_s)
      sum = {1'b0, big_m} + {1'b0, small_al};
    else if (big_m >= small_al)
      sum = {1'b0, big_m} - {1'b0, small_al};
    else
    begin
      sum = {1'b0, small_al} - {1'b0, big_m};
      sum_sign = small_s;
    end
  end

  // normalizer input by operation
  always_comb
  begin
    unique case (op_reg)
      fpu_pkg::multiply_single_regs:
      begin
        n_sign = fa[63] ^ fb[63];
        n_exp = {3'h0, fa[62:56]} + {3'h0, fb[62:56]} - `EXP_BIAS;
        n_mant = {product, 12'h000};
      end
      fpu_pkg::normalize_float:
      begin
        n_sign = fa[63];
        n_exp = {3'h0, fa[62:56]};
        n_mant = {fa[55:0], 4'h0};
      end
      default:
      begin
        n_sign = sum_sign;
        n_exp = {3'h0, a_big ? fa[62:56] : fb[62:56]} + {9'h000, sum[60]};
        n_mant = sum[60] ? {3'h0, sum[60:4]} : sum[59:0];
      end
    endcase
  end

  fpu_normalizer norm
  (
    .sign_in(n_sign),
    .exp_in(n_exp),
    .mant_in(n_mant),
    .result(n_result),
    .exp_over(n_over),
    .exp_under(n_under)
  );

  // scale: accumulator zero exponent minus register exponent
  assign scale_diff = {3'h0, ac0_reg[14:8]} - {3'h0, fa[62:56]};
  assign scale_amt = scale_diff[9] ? 7'(-scale_diff) : scale_diff[6:0];

  hex_shifter scale_shift
  (
    .in_val({fa[55:0], 4'h0}),
    .amount(scale_amt),
    .left(scale_diff[9]),
    .out_val(scale_sh)
  );

  // per-operation result, flag events and skip decision
  always_comb
  begin
    res_val = fa;
    res_wr = 1'b0;
    set_ovf = 1'b0;
    set_unf = 1'b0;
    set_mof = 1'b0;
    skip = 1'b0;
    unique case (op_reg)
      fpu_pkg::multiply_single_regs:
      begin
        res_val = {n_result[63:32], 32'h0};
        res_wr = 1'b1;
        set_ovf = n_over;
        set_unf = n_under;
      end
      fpu_pkg::negate_float:
      begin
        res_val = {fa[63] ^ (fa != 64'h0), fa[62:0]};
        res_wr = 1'b1;
      end
      fpu_pkg::normalize_float:
      begin
        res_val = n_result;
        res_wr = 1'b1;
        set_unf = n_under;
      end
      fpu_pkg::scale_float:
      begin
        if (scale_diff != 10'h000 && fa != 64'h0)
        begin
          res_wr = 1'b1;
          set_mof = scale_diff[9];
          if (scale_sh[59:4] == 56'h0)
            res_val = 64'h0;
          else
            res_val = {fa[63], ac0_reg[14:8], scale_sh[59:4]};
        end
      end
      fpu_pkg::subtract_double_regs, fpu_pkg::subtract_double_memory:
      begin
        res_val = n_result;
        res_wr = 1'b1;
        set_ovf = n_over;
        set_unf = n_under;
      end
      fpu_pkg::subtract_single_memory:
      begin
        res_val = {n_result[63:32], 32'h0};
        res_wr = 1'b1;
        set_ovf = n_over;
        set_unf = n_under;
      end
      fpu_pkg::float_skip_always: skip = 1'b1;
      fpu_pkg::skip_on_zero: skip = fsr_reg[`FSR_ZERO];
      fpu_pkg::skip_on_nonzero: skip = !fsr_reg[`FSR_ZERO];
      fpu_pkg::skip_on_ge_zero: skip = !fsr_reg[`FSR_NEG];
      fpu_pkg::skip_on_lt_zero: skip = fsr_reg[`FSR_NEG];
      fpu_pkg::skip_on_gt_zero: skip = !fsr_reg[`FSR_ZERO] && !fsr_reg[`FSR_NEG];
      fpu_pkg::skip_on_le_zero: skip = fsr_reg[`FSR_ZERO] || fsr_reg[`FSR_NEG];
      fpu_pkg::skip_on_no_error: skip = fsr_reg[`FSR_OVF:`FSR_MOF] == 4'h0;
      fpu_pkg::skip_on_no_divide_fault: skip = !fsr_reg[`FSR_DVZ];
      fpu_pkg::skip_on_no_mantissa_overflow: skip = !fsr_reg[`FSR_MOF];
      fpu_pkg::skip_on_no_overflow: skip = !fsr_reg[`FSR_OVF];
      fpu_pkg::skip_on_no_underflow: skip = !fsr_reg[`FSR_UNF];
      fpu_pkg::skip_no_overflow_no_divide_fault:
        skip = !fsr_reg[`FSR_OVF] && !fsr_reg[`FSR_DVZ];
      fpu_pkg::skip_no_underflow_no_divide_fault:
        skip = !fsr_reg[`FSR_UNF] && !fsr_reg[`FSR_DVZ];
      fpu_pkg::skip_no_underflow_no_overflow:
        skip = !fsr_reg[`FSR_UNF] && !fsr_reg[`FSR_OVF];
      default: skip = 1'b0;
    endcase
  end

  // float registers and status: software in idle, results, pop commit
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int r = 0; r < 4; r++)
        freg_reg[r] <= 64'h0;
      fsr_reg <= 32'h0;
    end
    else if (pop_fin)
    begin
      fsr_reg <= {shadow_reg[0], shadow_reg[1]};
      for (int r = 0; r < 4; r++)
        freg_reg[r] <= {shadow_reg[2 + 4 * r], shadow_reg[3 + 4 * r],
                        shadow_reg[4 + 4 * r], shadow_reg[5 + 4 * r]};
    end
    else if (exec_fin && res_wr)
    begin
      freg_reg[dst_reg] <= res_val;
      fsr_reg[`FSR_ZERO] <= res_val[55:0] == 56'h0;
      fsr_reg[`FSR_NEG] <= res_val[63];
      fsr_reg[`FSR_OVF] <= fsr_reg[`FSR_OVF] | set_ovf;
      fsr_reg[`FSR_UNF] <= fsr_reg[`FSR_UNF] | set_unf;
      fsr_reg[`FSR_MOF] <= fsr_reg[`FSR_MOF] | set_mof;
      fsr_reg[`FSR_ANY] <= (fsr_reg[`FSR_OVF:`FSR_MOF] != 4'h0) | set_ovf | set_unf | set_mof;
    end
    else if (sw_idle && wr_en)
    begin
      if (dp_addr_reg == `REG_FSR)
        fsr_reg <= hwdata;
      else if (dp_addr_reg >= `REG_FREG0 && dp_addr_reg < `REG_FREG_END)
      begin
        if (dp_addr_reg[2])
          freg_reg[dp_addr_reg[4:3]][31:0] <= hwdata;
        else
          freg_reg[dp_addr_reg[4:3]][63:32] <= hwdata;
      end
    end
  end

  // accumulator zero, program counter and stack pointer
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ac0_reg <= 16'h0000;
      pc_reg <= 16'h0000;
      sp_reg <= 16'h0000;
    end
    else if (exec_fin)
    begin
      if (op_reg == fpu_pkg::read_float_high_word)
        ac0_reg <= fa[63:48];
      pc_reg <= pc_reg + 16'h0001 + {15'h0000, skip};
    end
    else if (push_fin || pop_fin)
    begin
      pc_reg <= pc_reg + 16'h0001;
      sp_reg <= push_fin ? sp_reg + {11'h000, `BLOCK_WORDS}
                         : sp_reg - {11'h000, `BLOCK_WORDS};
    end
    else if (sw_idle && wr_en)
    begin
      if (dp_addr_reg == `REG_AC0)
        ac0_reg <= hwdata[15:0];
      if (dp_addr_reg == `REG_PC)
        pc_reg <= hwdata[15:0];
      if (dp_addr_reg == `REG_SP)
        sp_reg <= hwdata[15:0];
    end
  end

  // block word k: status high, status low, then each register high word first
  always_comb
  begin
    logic [4:0] k;
    k = cnt_reg - 5'h02;
    if (cnt_reg == 5'h00)
      push_word = fsr_reg[31:16];
    else if (cnt_reg == 5'h01)
      push_word = fsr_reg[15:0];
    else
      push_word = freg_reg[k[3:2]][63 - 16 * k[1:0] -: 16];
  end

  assign push_idx = sp_reg[4:0] + 5'h01 + cnt_reg;
  assign pop_idx = sp_reg[4:0] - `BLOCK_LAST + cnt_reg;

  // stack memory and operand words; push only reads float state
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 4; i++)
        opw_reg[i] <= 16'h0000;
    end
    else if (state_reg == fpu_pkg::st_push)
      stack_mem[push_idx] <= push_word;
    else if (sw_idle && wr_en)
    begin
      if (dp_addr_reg >= `REG_STACK0 && dp_addr_reg < `REG_STACK_END)
        stack_mem[dp_addr_reg[6:2]] <= hwdata[15:0];
      if (dp_addr_reg >= `REG_OPW0 && dp_addr_reg < `REG_OPW0 + 12'h010)
        opw_reg[dp_addr_reg[3:2] - 2'h2] <= hwdata[15:0];
    end
  end

  // pop gathers the block into a shadow before committing
  always_ff @(posedge clk)
  begin
    if (state_reg == fpu_pkg::st_pop && cnt_reg < `BLOCK_WORDS)
      shadow_reg[cnt_reg] <= stack_mem[pop_idx];
  end
endmodule // float_unit

// [verilog/fpu_map.svh]
// float unit constants: bus offsets, command fields, status bit positions
// assumes inclusion by bare name from the float unit design files
`ifndef FPU_MAP_SVH
`define FPU_MAP_SVH
// register byte offsets within the 4 KiB slave window
`define REG_CMD 12'h000
`define REG_STATUS 12'h004
`define REG_FSR 12'h008
`define REG_AC0 12'h00C
`define REG_PC 12'h010
`define REG_SP 12'h014
`define REG_OPW0 12'h018
`define REG_FREG0 12'h040
`define REG_FREG_END 12'h060
`define REG_STACK0 12'h100
`define REG_STACK_END 12'h180
// command word fields
`define CMD_OP_MSB 4
`define CMD_SRC_LSB 8
`define CMD_DST_LSB 12
// status register bits, bit 0 of the printed layout is bit 31 here
`define FSR_ANY 31
`define FSR_OVF 30
`define FSR_UNF 29
`define FSR_DVZ 28
`define FSR_MOF 27
`define FSR_ZERO 25
`define FSR_NEG 24
// arithmetic constants
`define EXP_BIAS 10'h040
`define BLOCK_WORDS 5'h12
`define BLOCK_LAST 5'h11
`define HEX_DIGITS 4'hF
`endif

// [verilog/fpu_pkg.sv]
// float unit types: operation codes and sequencer states
// assumes nothing beyond a SystemVerilog compiler
package fpu_pkg;
  // operation codes in command word bits 4:0, numbered in this order from zero
  typedef enum logic [4:0] {
    multiply_single_regs, negate_float, normalize_float, float_no_skip,
    float_skip_always, pop_float_state, push_float_state, read_float_high_word,
    scale_float, subtract_double_regs, subtract_double_memory, subtract_single_memory,
    skip_on_zero, skip_on_nonzero, skip_on_ge_zero, skip_on_lt_zero, skip_on_gt_zero,
    skip_on_le_zero, skip_on_no_error, skip_on_no_divide_fault,
    skip_on_no_mantissa_overflow, skip_on_no_overflow, skip_on_no_underflow,
    skip_no_overflow_no_divide_fault, skip_no_underflow_no_divide_fault,
    skip_no_underflow_no_overflow
  } op_e;
  typedef enum {st_idle, st_exec, st_push, st_pop} seq_state_e;
endpackage

// [verilog/hex_shifter.sv]
// hex digit shifter for a 60-bit mantissa with guard digit
// assumes the caller discards whatever leaves either end
`timescale 1ns/1ps
`include "fpu_map.svh"
module hex_shifter
(
  input wire logic [59:0] in_val,
  input wire logic [6:0] amount,
  input wire logic left,
  output logic [59:0] out_val
);
  logic [5:0] bit_shift;

  // digits beyond the width clear the whole mantissa
  assign bit_shift = {amount[3:0], 2'b00};
  always_comb
  begin
    if (amount >= {3'h0, `HEX_DIGITS})
      out_val = 60'h0;
    else if (left)
      out_val = in_val << bit_shift;
    else
      out_val = in_val >> bit_shift;
  end
endmodule // hex_shifter

// [verilog/fpu_normalizer.sv]
// normalizer: shifts leading zero hex digits out and adjusts the exponent
// assumes a signed 10-bit exponent and a mantissa with one guard digit
`timescale 1ns/1ps
`include "fpu_map.svh"
module fpu_normalizer
(
  input wire logic sign_in,
  input wire logic [9:0] exp_in,
  input wire logic [59:0] mant_in,
  output logic [63:0] result,
  output logic exp_over,
  output logic exp_under
);
  logic [3:0] lead_zero;
  logic [59:0] shifted;
  logic [9:0] exp_out;

  // count leading zero digits of the mantissa
  always_comb
  begin
    lead_zero = `HEX_DIGITS;
    for (int i = 0; i < 15; i++)
    begin
      if (lead_zero == `HEX_DIGITS && mant_in[59 - 4 * i -: 4] != 4'h0)
        lead_zero = 4'(i);
    end
  end

  assign shifted = mant_in << {lead_zero, 2'b00};
  assign exp_out = exp_in - {6'h00, lead_zero};

  // zero mantissa gives pure zero; exponent wraps by 128 on range error
  always_comb
  begin
    if (mant_in == 60'h0)
    begin
      result = 64'h0;
      exp_over = 1'b0;
      exp_under = 1'b0;
    end
    else
    begin
      result = {sign_in, exp_out[6:0], shifted[59:4]};
      exp_over = $signed(exp_out) > $signed(10'h07F);
      exp_under = $signed(exp_out) < $signed(10'h000);
    end
  end
endmodule // fpu_normalizer

// [verification/float_unit_monitor.sv]
// checker for float_unit: bus answer timing, command completion and abort
// assumes binding into float_unit, one clock, synchronous active-low reset
`timescale 1ns/1ps
module float_unit_monitor
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic intr_req,
  input wire logic busy,
  input wire logic done,
  input wire logic skip_taken
);
  logic [5:0] run_reg;
  wire logic take = hsel && htrans[1] && hready;
  // length of the current busy stretch
  always_ff @(posedge clk)
  begin
    if (!rstn)
      run_reg <= 6'h00;
    else
      run_reg <= busy ? run_reg + 6'h01 : 6'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_READ_WAIT:
  assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  AST_WRITE_NOWAIT:
  assert property (take && hwrite |=> hreadyout) else $error("write wait");
  AST_DONE_PULSE:
  assert property (done |=> !done) else $error("done too long");
  AST_DONE_AFTER:
  assert property (done |-> !busy && $past(busy)) else $error("done without busy");
  AST_SKIP_HOLD:
  assert property (!done |-> $stable(skip_taken)) else $error("skip moved");
  AST_END_DONE:
  assert property ($fell(busy) && !$past(intr_req) |-> done) else $error("no done");
  AST_ABORT:
  assert property (busy && intr_req && $past(busy) |=> !done && !busy) else $error("no abort");
  AST_BUSY_LEN:
  assert property (run_reg <= 6'h13) else $error("busy too long");
  cover property (done && skip_taken);
  cover property (run_reg == 6'h12);
  cover property (busy && intr_req && $past(busy));
endmodule // float_unit_monitor
bind float_unit float_unit_monitor mon (.clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .intr_req(intr_req),
  .busy(busy), .done(done), .skip_taken(skip_taken));

// [verification/seq_model.sv]
// sequencer model: one interrupt cycle a set time after a go request
// assumes the float unit clock; go comes from the bench
`timescale 1ns/1ps
module seq_model
#(parameter int DELAY = 6)
(
  input wire logic clk,
  input wire logic go,
  output logic intr_req
);
  int cnt = -1;
  initial intr_req = 1'b0;
  // count from go, then interrupt once
  always @(posedge clk)
  begin
    intr_req <= (cnt == DELAY);
    cnt <= go ? 0 : (cnt >= 0 && cnt <= DELAY) ? cnt + 1 : -1;
  end
endmodule // seq_model

// [verification/float_unit_test.sv]
// self-checking bench for float_unit over its AHB-Lite port
// assumes fpu_map.svh offsets and one wait state on reads
`timescale 1ns/1ps
`include "fpu_map.svh"
module float_unit_test;
  localparam logic [31:0] all_m = 32'hFFFFFFFF;
  localparam logic [31:0] zn_m = 32'h03000000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic rd_pend = 1'b0;
  logic hreadyout, hresp, intr_req, busy, done, skip_taken;
  logic [31:0] hrdata, rdata, f;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] pc = 16'h0;
  logic [4:0] op;
  int failures = 0, num_checks = 0, cyc = 0;
  float_unit DUT (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .intr_req(intr_req),
    .busy(busy), .done(done), .skip_taken(skip_taken));
  seq_model seq (.clk(clk), .go(go), .intr_req(intr_req));
  initial forever #12.5 clk = ~clk;
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one single transfer; a read leaves a note of the expected word
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, m);
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
    xfer(1'b0, a, e, m);
  endtask
  function automatic logic [11:0] fa(input logic [1:0] i);
    return `REG_FREG0 + {7'h0, i, 3'h0};
  endfunction
  task automatic wf(input logic [1:0] i, input logic [31:0] hi, lo);
    wr(fa(i), hi);
    wr(fa(i) + 12'h4, lo);
  endtask
  // poll status until the command has left busy
  task automatic idle();
    int n = 0;
    do
    begin
      rd(`REG_STATUS, 32'h0, 32'h0);
      n++;
    end
    while (rdata[0] !== 1'b0 && n < 40);
    if (rdata[0] !== 1'b0)
    begin
      failures++;
      $display("[ERR] %0t command never left busy", $time);
    end
  endtask
  task automatic cmd(input logic [4:0] c, input logic [1:0] s, d, input logic sk);
    wr(`REG_CMD, {18'h0, d, 2'h0, s, 3'h0, c});
    idle();
    pc = pc + 16'h1 + sk;
    rd(`REG_STATUS, {30'h0, sk, 1'b0}, 32'h3);
    rd(`REG_PC, {16'h0, pc}, 32'hFFFF);
  endtask
  // skip outcome for every op code from the status flags
  function automatic logic skip_of(input logic [4:0] c, input logic [31:0] s);
    logic o, u, d, m, z, n;
    logic [25:0] v;
    {o, u, d, m} = s[30:27];
    {z, n} = s[25:24];
    v = {!(u | o), !(u | d), !(o | d), !u, !o, !m, !d, !(o | u | d | m), z | n, !(z | n),
      n, !n, !z, z, 7'h0, 1'b1, 4'h0};
    return v[c];
  endfunction
  // compare each read answer with the oldest note
  always @(posedge clk)
  begin
    if (rd_pend && hreadyout)
    begin
      if (msk_q[0] != 32'h0)
        num_checks++;
      if ((hrdata & msk_q[0]) !== (exp_q[0] & msk_q[0]))
      begin
        failures++;
        $display("[ERR] %0t read %h expected %h", $time, hrdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (hreadyout)
      rd_pend <= htrans[1] && !hwrite;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      failures++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(13));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(12'h800, all_m);
    rd(12'h800, 32'h0, all_m);
    // every skip op against random status flags
    for (int k = 0; k < 48; k++)
    begin
      f = $urandom & $urandom & 32'h7B000000;
      op = (k % 16 < 2) ? 5'(3 + k % 16) : 5'(10 + k % 16);
      wr(`REG_FSR, f);
      cmd(op, 2'h0, 2'h0, skip_of(op, f));
    end
    wr(`REG_FSR, 32'h0);
    wf(2'h0, 32'h41100000, 32'h12345678);
    wf(2'h1, 32'h0, 32'h0);
    cmd(5'h01, 2'h0, 2'h0, 1'b0);
    rd(fa(2'h0), 32'hC1100000, all_m);
    rd(fa(2'h0) + 12'h4, 32'h12345678, all_m);
    rd(`REG_FSR, 32'h01000000, zn_m);
    cmd(5'h01, 2'h0, 2'h1, 1'b0);
    rd(fa(2'h1), 32'h0, all_m);
    // normalize: plain, impure zero, underflow
    wf(2'h2, 32'h41010000, 32'h0);
    wf(2'h3, 32'hC5000000, 32'h0);
    cmd(5'h02, 2'h0, 2'h2, 1'b0);
    rd(fa(2'h2), 32'h40100000, all_m);
    cmd(5'h02, 2'h0, 2'h3, 1'b0);
    rd(fa(2'h3), 32'h0, all_m);
    wf(2'h3, 32'h00010000, 32'h0);
    cmd(5'h02, 2'h0, 2'h3, 1'b0);
    rd(fa(2'h3), 32'h7F100000, all_m);
    rd(`REG_FSR, 32'h20000000, 32'h20000000);
    // multiply with junk in the low half
    wf(2'h0, 32'h41200000, all_m);
    wf(2'h1, 32'h41300000, 32'h0);
    cmd(5'h00, 2'h1, 2'h0, 1'b0);
    rd(fa(2'h0), 32'h41600000, all_m);
    rd(fa(2'h0) + 12'h4, 32'h0, all_m);
    rd(fa(2'h1), 32'h41300000, all_m);
    // read high word, then scale right and left
    cmd(5'h07, 2'h0, 2'h0, 1'b0);
    rd(`REG_AC0, 32'h00004160, all_m);
    wr(`REG_AC0, 32'h00004300);
    cmd(5'h08, 2'h0, 2'h0, 1'b0);
    rd(fa(2'h0), 32'h43006000, all_m);
    rd(`REG_AC0, 32'h00004300, all_m);
    wr(`REG_AC0, 32'h00004000);
    cmd(5'h08, 2'h0, 2'h0, 1'b0);
    rd(fa(2'h0), 32'h0, all_m);
    rd(`REG_FSR, 32'h0A000000, 32'h0B000000);
    // subtract from register and from two or four operand words
    wf(2'h2, 32'h41100000, 32'h0);
    cmd(5'h09, 2'h2, 2'h1, 1'b0);
    rd(fa(2'h1), 32'h41200000, all_m);
    rd(fa(2'h2), 32'h41100000, all_m);
    wr(`REG_OPW0, 32'h00004120);
    wr(`REG_OPW0 + 12'hC, 32'h1);
    cmd(5'h0B, 2'h0, 2'h1, 1'b0);
    rd(`REG_FSR, 32'h02000000, zn_m);
    wf(2'h1, 32'h41200000, 32'h0);
    cmd(5'h0A, 2'h0, 2'h1, 1'b0);
    rd(`REG_FSR, 32'h01000000, zn_m);
    // push, pop, then a push cut short by the sequencer
    wf(2'h0, 32'hABCD1234, 32'h0);
    cmd(5'h06, 2'h0, 2'h0, 1'b0);
    rd(`REG_SP, 32'h12, 32'hFFFF);
    rd(`REG_STACK0 + 12'hC, 32'hABCD, 32'hFFFF);
    rd(fa(2'h0), 32'hABCD1234, all_m);
    wf(2'h0, 32'h0, 32'h0);
    cmd(5'h05, 2'h0, 2'h0, 1'b0);
    rd(fa(2'h0), 32'hABCD1234, all_m);
    go <= 1'b1;
    wr(`REG_CMD, 32'h6);
    go <= 1'b0;
    idle();
    rd(`REG_SP, 32'h0, 32'hFFFF);
    rd(`REG_PC, {16'h0, pc}, 32'hFFFF);
    final_report();
  end
endmodule // float_unit_test
